// >>> design/ext_pm_qualifier.sv
// ext_pm_qualifier: synchronises and width-qualifies the external request
// assumes the request is a slow level from a switch or another chip
`timescale 1ns/1ps
module ext_pm_qualifier
	import idle_timer_pkg::*;
#(
	parameter int unsigned LONG_CYCLES = EXT_LONG_CYCLES
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// control
	input  wire logic active_high_i,
	input  wire logic long_width_i,
	// request in, qualified pulse out
	input  wire logic req_i,
	output logic      qual_o
);
	localparam int unsigned QW = $clog2(LONG_CYCLES + 1);

	logic          sync1_reg;
	logic          sync2_reg;
	logic [QW-1:0] cnt_reg;
	logic [QW-1:0] cnt_next;
	logic          done_reg;
	logic          done_next;
	logic          active;
	logic [QW-1:0] need;

	always_comb begin
		active    = sync2_reg ^ ~active_high_i;
		need      = long_width_i ? QW'(LONG_CYCLES) : QW'(EXT_SHORT_CYCLES);
		cnt_next  = cnt_reg;
		done_next = done_reg;
		qual_o    = 1'b0;
		if (!active) begin
			cnt_next  = '0;
			done_next = 1'b0;
		end else if (!done_reg) begin
			if (cnt_reg + QW'(1) >= need) begin
				qual_o    = 1'b1;
				done_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + QW'(1);
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			cnt_reg   <= '0;
			done_reg  <= 1'b0;
		end else begin
			sync1_reg <= req_i;
			sync2_reg <= sync1_reg;
			cnt_reg   <= cnt_next;
			done_reg  <= done_next;
		end
	end

endmodule : ext_pm_qualifier

// >>> design/idle_activity_timer.sv
// idle_activity_timer: inactivity countdown, activity detection and wake-up
// assumes all inputs synchronous to CORE_CLK_I except the external request
// Function
// - enabled external request reloads or wakes
// - external request polarity and width qualified
// - writing one forces low power if allowed
// - three-bit code selects eight idle periods
// - one inactivity timer, reloaded by every enabled activity source
// - enabled irq in low power wakes
// - wake reloads timer and asserts restore
// - enabled irq in full power reloads
// - high enable register maps irq15..8
// - mode bit zero allows forced entry
// - mode bit six gates restore output
// - expiry enters low power when enabled
`timescale 1ns/1ps
module idle_activity_timer
	import idle_timer_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES,
	parameter int unsigned EXT_LONG = EXT_LONG_CYCLES
) (
	// clock and reset
	input  wire logic              CORE_CLK_I,
	input  wire logic              SYS_RST_I,
	// apb slave
	input  wire logic              PSEL_I,
	input  wire logic              PENABLE_I,
	input  wire logic              PWRITE_I,
	input  wire logic [ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]       PWDATA_I,
	input  wire logic [3:0]        PSTRB_I,
	output logic      [31:0]       PRDATA_O,
	output logic                   PREADY_O,
	output logic                   PSLVERR_O,
	// activity sources
	input  wire logic [15:0]       IRQ_I,
	input  wire logic              VECTOR_ACCESS_I,
	input  wire logic              EXT_PM_REQUEST_I,
	// power control
	output logic                   LOW_POWER_O,
	output logic                   POWER_RESTORE_EN_O,
	output logic                   IRQ_O
);
	localparam int unsigned TW = $clog2(TICK_LEN + 1);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction : hit

	// register state
	mode_t            mode_reg;
	mode_t            mode_next;
	idle_cfg_t        cfg_reg;
	idle_cfg_t        cfg_next;
	logic [7:0]       irq_low_reg;
	logic [7:0]       irq_low_next;
	logic [7:0]       irq_high_reg;
	logic [7:0]       irq_high_next;
	logic [INT_W-1:0] int_stat_reg;
	logic [INT_W-1:0] int_stat_next;
	logic [INT_W-1:0] int_mask_reg;
	logic [INT_W-1:0] int_mask_next;
	logic             timer_stat_reg;
	logic             timer_stat_next;
	logic             forced_stat_reg;
	logic             forced_stat_next;
	// timer and power state
	power_state_t     state_reg;
	power_state_t     state_next;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic [TW-1:0]    tick_reg;
	logic [TW-1:0]    tick_next;
	logic             expired_reg;
	logic             expired_next;
	logic [15:0]      irq_prev_reg;
	logic             restore_reg;
	logic             restore_next;
	logic [31:0]      rdata_reg;
	logic [31:0]      rdata_next;
	logic             slverr_reg;
	logic             slverr_next;
	// events
	logic             wr;
	logic             rd;
	logic             mapped;
	logic             ext_qual;
	logic [15:0]      irq_en;
	logic             irq_hit;
	logic             activity;
	logic             wake;
	logic             reload;
	logic             expire;
	logic             force_go;
	logic             enter_idle;
	logic [7:0]       wbyte;

	ext_pm_qualifier #(
		.LONG_CYCLES (EXT_LONG)
	) u_ext_qual (
		.clk_i         (CORE_CLK_I),
		.rst_i         (SYS_RST_I),
		.active_high_i (cfg_reg.ext_pm_high),
		.long_width_i  (cfg_reg.ext_pm_long),
		.req_i         (EXT_PM_REQUEST_I),
		.qual_o        (ext_qual)
	);

	// apb decode
	always_comb begin
		wr     = PSEL_I & PENABLE_I & PWRITE_I & PSTRB_I[0];
		rd     = PSEL_I & PENABLE_I & ~PWRITE_I;
		wbyte  = PWDATA_I[7:0];
		mapped = hit(PADDR_I, IDX_MODE) | hit(PADDR_I, IDX_TIMER_CFG)
			| hit(PADDR_I, IDX_IRQ_LOW) | hit(PADDR_I, IDX_IRQ_HIGH)
			| hit(PADDR_I, IDX_INT_STAT) | hit(PADDR_I, IDX_INT_MASK);
	end

	// activity and wake detection
	always_comb begin
		irq_en = {irq_high_reg[7:6], 1'b0, irq_high_reg[4:0],
			irq_low_reg[7:3], 1'b0, irq_low_reg[1], 1'b0};
		irq_hit  = |(irq_en & IRQ_I & ~irq_prev_reg);
		activity = irq_hit
			| (VECTOR_ACCESS_I & cfg_reg.vector_wake)
			| (ext_qual & cfg_reg.ext_pm_en);
		wake     = activity & (state_reg == ST_IDLE);
		reload   = activity;
		expire   = (count_reg == '0) & ~expired_reg;
		force_go = wr & hit(PADDR_I, IDX_TIMER_CFG) & wbyte[3] & mode_reg.forced_en;
		enter_idle = (state_reg == ST_FULL) & ~activity
			& (force_go | (expire & mode_reg.timer_en));
	end

	// power state, timer and prescaler
	always_comb begin
		state_next   = state_reg;
		count_next   = count_reg;
		tick_next    = tick_reg;
		expired_next = expired_reg;
		restore_next = 1'b0;
		unique case (state_reg)
			ST_FULL: begin
				if (enter_idle) begin
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (wake) begin
					state_next   = ST_FULL;
					restore_next = mode_reg.restore_en;
				end
			end
		endcase
		if (reload) begin
			count_next   = PERIOD_S[cfg_reg.period_sel];
			tick_next    = '0;
			expired_next = 1'b0;
		end else if (count_reg == '0) begin
			expired_next = 1'b1;
		end else if (tick_reg == TW'(TICK_LEN - 1)) begin
			tick_next  = '0;
			count_next = count_reg - CNT_W'(1);
		end else begin
			tick_next = tick_reg + TW'(1);
		end
	end

	// register writes, status and interrupts
	always_comb begin
		mode_next        = mode_reg;
		cfg_next         = cfg_reg;
		irq_low_next     = irq_low_reg;
		irq_high_next    = irq_high_reg;
		int_mask_next    = int_mask_reg;
		int_stat_next    = int_stat_reg;
		timer_stat_next  = timer_stat_reg;
		forced_stat_next = forced_stat_reg;
		if (wr && hit(PADDR_I, IDX_MODE)) begin
			mode_next            = mode_t'(wbyte);
			mode_next.full_power = 1'b0;
			if (!wbyte[2]) begin
				timer_stat_next = 1'b0;
			end
			if (!wbyte[0]) begin
				forced_stat_next = 1'b0;
			end
		end
		if (wr && hit(PADDR_I, IDX_TIMER_CFG)) begin
			cfg_next            = idle_cfg_t'(wbyte);
			cfg_next.force_idle = 1'b0;
		end
		if (wr && hit(PADDR_I, IDX_IRQ_LOW)) begin
			irq_low_next = wbyte & IRQ_LOW_USED;
		end
		if (wr && hit(PADDR_I, IDX_IRQ_HIGH)) begin
			irq_high_next = wbyte & IRQ_HIGH_USED;
		end
		if (wr && hit(PADDR_I, IDX_INT_MASK)) begin
			int_mask_next = wbyte[INT_W-1:0];
		end
		if (wr && hit(PADDR_I, IDX_INT_STAT)) begin
			int_stat_next = int_stat_reg & ~wbyte[INT_W-1:0];
		end
		// set wins over clear
		if (enter_idle && force_go) begin
			forced_stat_next = 1'b1;
		end else if (enter_idle) begin
			timer_stat_next = 1'b1;
		end
		if (wake) begin
			int_stat_next[INT_WAKE] = 1'b1;
		end
		if (enter_idle) begin
			int_stat_next[INT_IDLE] = 1'b1;
		end
	end

	// read data
	always_comb begin
		rdata_next  = rdata_reg;
		slverr_next = 1'b0;
		if (PSEL_I && !PENABLE_I) begin
			slverr_next = ~mapped;
			rdata_next  = '0;
			if (hit(PADDR_I, IDX_MODE)) begin
				rdata_next[7:0] = {mode_reg[7:4], state_reg == ST_FULL,
					timer_stat_reg, mode_reg.ext_pm_stat_en, forced_stat_reg};
			end
			if (hit(PADDR_I, IDX_TIMER_CFG)) begin
				rdata_next[7:0] = cfg_reg;
			end
			if (hit(PADDR_I, IDX_IRQ_LOW)) begin
				rdata_next[7:0] = irq_low_reg;
			end
			if (hit(PADDR_I, IDX_IRQ_HIGH)) begin
				rdata_next[7:0] = irq_high_reg;
			end
			if (hit(PADDR_I, IDX_INT_STAT)) begin
				rdata_next[INT_W-1:0] = int_stat_reg;
			end
			if (hit(PADDR_I, IDX_INT_MASK)) begin
				rdata_next[INT_W-1:0] = int_mask_reg;
			end
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			mode_reg        <= mode_t'(MODE_RST);
			cfg_reg         <= idle_cfg_t'(CFG_RST);
			irq_low_reg     <= IRQ_LOW_RST;
			irq_high_reg    <= IRQ_HIGH_RST;
			int_stat_reg    <= '0;
			int_mask_reg    <= '0;
			timer_stat_reg  <= 1'b0;
			forced_stat_reg <= 1'b0;
			state_reg       <= ST_FULL;
			count_reg       <= PERIOD_S[CFG_RST[2:0]];
			tick_reg        <= '0;
			expired_reg     <= 1'b0;
			irq_prev_reg    <= '0;
			restore_reg     <= 1'b0;
			rdata_reg       <= '0;
			slverr_reg      <= 1'b0;
		end else begin
			mode_reg        <= mode_next;
			cfg_reg         <= cfg_next;
			irq_low_reg     <= irq_low_next;
			irq_high_reg    <= irq_high_next;
			int_stat_reg    <= int_stat_next;
			int_mask_reg    <= int_mask_next;
			timer_stat_reg  <= timer_stat_next;
			forced_stat_reg <= forced_stat_next;
			state_reg       <= state_next;
			count_reg       <= count_next;
			tick_reg        <= tick_next;
			expired_reg     <= expired_next;
			irq_prev_reg    <= IRQ_I;
			restore_reg     <= restore_next;
			rdata_reg       <= rdata_next;
			slverr_reg      <= slverr_next;
		end
	end

	// outputs
	always_comb begin
		PRDATA_O           = rdata_reg;
		PREADY_O           = 1'b1;
		PSLVERR_O          = slverr_reg & PSEL_I & PENABLE_I;
		LOW_POWER_O        = (state_reg == ST_IDLE);
		POWER_RESTORE_EN_O = restore_reg;
		IRQ_O              = |(int_stat_reg & int_mask_reg);
	end

endmodule : idle_activity_timer

// >>> design/idle_timer_pkg.sv
// idle_timer_pkg: shared constants and types of the activity timer
// assumes a 250 MHz core clock and an APB register port
package idle_timer_pkg;

	// clock rate and timing figures
	localparam int unsigned CLK_MHZ          = 250;
	localparam int unsigned EXT_SHORT_NS     = 100;
	localparam int unsigned EXT_LONG_MS      = 5;
	localparam int unsigned TICK_S           = 1;
	localparam int unsigned EXT_SHORT_CYCLES = (EXT_SHORT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned EXT_LONG_CYCLES  = EXT_LONG_MS * 1000 * CLK_MHZ;
	localparam int unsigned TICK_CYCLES      = TICK_S * 1000000 * CLK_MHZ;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_MODE      = 8'hE0;
	localparam logic [7:0] IDX_TIMER_CFG = 8'hE1;
	localparam logic [7:0] IDX_IRQ_LOW   = 8'hE2;
	localparam logic [7:0] IDX_IRQ_HIGH  = 8'hE3;
	localparam logic [7:0] IDX_INT_STAT  = 8'hF0;
	localparam logic [7:0] IDX_INT_MASK  = 8'hF1;
	localparam int unsigned ADDR_W       = 10;

	// reset values and reserved-bit masks
	localparam logic [7:0] MODE_RST     = 8'h00;
	localparam logic [7:0] CFG_RST      = 8'h00;
	localparam logic [7:0] IRQ_LOW_RST  = 8'h00;
	localparam logic [7:0] IRQ_HIGH_RST = 8'h00;
	localparam logic [7:0] IRQ_LOW_USED = 8'hFA;
	localparam logic [7:0] IRQ_HIGH_USED = 8'hDF;

	// interrupt status bit positions
	localparam int unsigned INT_WAKE = 0;
	localparam int unsigned INT_IDLE = 1;
	localparam int unsigned INT_W    = 2;

	// countdown in seconds for each period code
	localparam int unsigned CNT_W = 14;
	localparam logic [CNT_W-1:0] PERIOD_S [8] = '{
		14'h000F, 14'h0078, 14'h012C, 14'h0384,
		14'h0708, 14'h0A8C, 14'h0E10, 14'h3840};

	// timer configuration layout
	typedef struct packed {
		logic       vector_wake;
		logic       ext_pm_en;
		logic       ext_pm_long;
		logic       ext_pm_high;
		logic       force_idle;
		logic [2:0] period_sel;
	} idle_cfg_t;

	// mode register layout
	typedef struct packed {
		logic idle_mode_sel;
		logic restore_en;
		logic intr_idle_en;
		logic irq15_en;
		logic full_power;
		logic timer_en;
		logic ext_pm_stat_en;
		logic forced_en;
	} mode_t;

	typedef enum logic {
		ST_FULL = 1'b0,
		ST_IDLE = 1'b1
	} power_state_t;

endpackage : idle_timer_pkg

// >>> tb/activity_source.sv
// activity_source: interrupt lines, vector accesses and external request
// assumes the bench commands it through its tasks
`timescale 1ns/1ps
module activity_source (
	// clock
	input  wire logic        clk_i,
	// activity out
	output logic      [15:0] irq_o,
	output logic             vec_o,
	output logic             ext_o
);
	initial begin
		irq_o = 16'h0000;
		vec_o = 1'b0;
		ext_o = 1'b1;
	end

	// one irq line high for two cycles
	task automatic irq_pulse(input int n);
		@(posedge clk_i);
		irq_o[n] <= 1'b1;
		repeat (2) @(posedge clk_i);
		irq_o[n] <= 1'b0;
	endtask : irq_pulse

	task automatic vec_pulse();
		@(posedge clk_i);
		vec_o <= 1'b1;
		@(posedge clk_i);
		vec_o <= 1'b0;
	endtask : vec_pulse

	// request active for len cycles, then inactive
	task automatic ext_pulse(input logic act, input int len);
		@(posedge clk_i);
		ext_o <= act;
		repeat (len) @(posedge clk_i);
		ext_o <= ~act;
	endtask : ext_pulse

	task automatic ext_idle(input logic lvl);
		@(posedge clk_i);
		ext_o <= lvl;
	endtask : ext_idle
endmodule : activity_source

// >>> tb/activity_timer_checker.sv
// activity_timer_checker: port-level properties of the activity timer
// assumes a bind into idle_activity_timer, one clock domain
`timescale 1ns/1ps
module activity_timer_checker
	import idle_timer_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES,
	parameter int unsigned EXT_LONG = EXT_LONG_CYCLES
) (
	// clock, reset and apb
	input  wire logic              CORE_CLK_I,
	input  wire logic              SYS_RST_I,
	input  wire logic              PSEL_I,
	input  wire logic              PENABLE_I,
	input  wire logic              PWRITE_I,
	input  wire logic [ADDR_W-1:0] PADDR_I,
	input  wire logic [31:0]       PRDATA_O,
	input  wire logic              PSLVERR_O,
	// activity and power
	input  wire logic [15:0]       IRQ_I,
	input  wire logic              VECTOR_ACCESS_I,
	input  wire logic              EXT_PM_REQUEST_I,
	input  wire logic              LOW_POWER_O,
	input  wire logic              POWER_RESTORE_EN_O,
	input  wire logic              IRQ_O
);
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);

	property p_err_map;
		PSEL_I && PENABLE_I |-> PSLVERR_O == !(PADDR_I inside {10'h380, 10'h384, 10'h388, 10'h38C, 10'h3C0, 10'h3C4});
	endproperty
	property p_err_gate;
		PSLVERR_O |-> PSEL_I && PENABLE_I;
	endproperty
	property p_rdata_hi;
		PRDATA_O[31:8] == 24'h000000;
	endproperty
	property p_rdata_hold;
		!(PSEL_I && !PENABLE_I) |=> $stable(PRDATA_O);
	endproperty
	property p_restore_cause;
		POWER_RESTORE_EN_O |-> !LOW_POWER_O && $past(LOW_POWER_O);
	endproperty
	property p_restore_pulse;
		POWER_RESTORE_EN_O |=> !POWER_RESTORE_EN_O;
	endproperty
	property p_wake_source;
		$fell(LOW_POWER_O) |-> $past(VECTOR_ACCESS_I) || ($past(IRQ_I) & ~$past(IRQ_I, 2)) != 16'h0000
			|| $past(EXT_PM_REQUEST_I, 3) == $past(EXT_PM_REQUEST_I, 8);
	endproperty
	property p_irq_cause;
		$rose(IRQ_O) |-> $changed(LOW_POWER_O) || $past(PSEL_I && PENABLE_I && PWRITE_I);
	endproperty

	a_err_map:       assert property (p_err_map) else $error("slave error does not follow address");
	a_err_gate:      assert property (p_err_gate) else $error("slave error outside access phase");
	a_rdata_hi:      assert property (p_rdata_hi) else $error("read data upper bits not zero");
	a_rdata_hold:    assert property (p_rdata_hold) else $error("read data moved in access phase");
	a_restore_cause: assert property (p_restore_cause) else $error("restore without leaving low power");
	a_restore_pulse: assert property (p_restore_pulse) else $error("restore longer than one cycle");
	a_wake_source:   assert property (p_wake_source) else $error("low power left without activity");
	a_irq_cause:     assert property (p_irq_cause) else $error("interrupt raised without event");

	c_sleep: cover property ($rose(LOW_POWER_O));
	c_wake:  cover property (POWER_RESTORE_EN_O);
	c_err:   cover property (PSLVERR_O);
endmodule : activity_timer_checker

bind idle_activity_timer activity_timer_checker #(.TICK_LEN(TICK_LEN), .EXT_LONG(EXT_LONG)) chk (
	.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .IRQ_I(IRQ_I),
	.VECTOR_ACCESS_I(VECTOR_ACCESS_I), .EXT_PM_REQUEST_I(EXT_PM_REQUEST_I), .LOW_POWER_O(LOW_POWER_O),
	.POWER_RESTORE_EN_O(POWER_RESTORE_EN_O), .IRQ_O(IRQ_O)
);

// >>> tb/tb.sv
// tb: self-checking bench of the activity timer
// assumes package, design, source model and checker compiled before it
`timescale 1ns/1ps
module tb
	import idle_timer_pkg::*;
();
	logic        clk      = 1'b0;
	logic        rst      = 1'b1;
	logic        psel     = 1'b0;
	logic        penable  = 1'b0;
	logic        pwrite   = 1'b0;
	logic [9:0]  paddr    = 10'h000;
	logic [31:0] pwdata   = 32'h00000000;
	logic [3:0]  pstrb    = 4'h1;
	logic [31:0] wake_cnt = 32'h00000000;
	logic [31:0] cyc      = 32'h00000000;
	logic [31:0] prdata;
	logic [15:0] irq;
	logic [7:0]  rd;
	logic        pready, pslverr, vec, ext, low, restore, intr, e;
	int          error_cnt  = 0;
	int          n_compared = 0;
	int          n;
	int          per [3] = '{15, 120, 300};
	int          lines [11] = '{1, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14};

	always #2 clk = ~clk;

	idle_activity_timer #(.TICK_LEN(4), .EXT_LONG(50)) dut (
		.CORE_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(pslverr), .IRQ_I(irq), .VECTOR_ACCESS_I(vec), .EXT_PM_REQUEST_I(ext),
		.LOW_POWER_O(low), .POWER_RESTORE_EN_O(restore), .IRQ_O(intr)
	);
	activity_source src (.clk_i(clk), .irq_o(irq), .vec_o(vec), .ext_o(ext));

	always @(posedge clk) begin
		cyc <= cyc + 32'h1;
		if (restore === 1'b1)
			wake_cnt <= wake_cnt + 32'h1;
		if (cyc == 32'h4E20) begin
			error_cnt++;
			final_report();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= {idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata[7:0];
		e  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		check({23'h000000, e, rd}, {24'h000000, exp});
	endtask : rdc

	task automatic expect_wakes(input logic [31:0] w, input logic lp);
		repeat (4) @(posedge clk);
		@(negedge clk);
		check(wake_cnt, w);
		check({31'h00000000, low}, {31'h00000000, lp});
	endtask : expect_wakes

	task automatic chk_irq(input logic exp);
		@(negedge clk);
		check({31'h00000000, intr}, {31'h00000000, exp});
	endtask : chk_irq

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdc(IDX_MODE, 8'h08);
		rdc(IDX_TIMER_CFG, 8'h00);
		rdc(IDX_IRQ_LOW, 8'h00);
		rdc(IDX_IRQ_HIGH, 8'h00);
		apb(1'b0, 8'hE4, 8'h00);
		check({31'h00000000, e}, 32'h00000001);
		apb(1'b1, IDX_IRQ_LOW, 8'hFA);
		rdc(IDX_IRQ_LOW, 8'hFA);
		apb(1'b1, IDX_IRQ_HIGH, 8'hFF);
		rdc(IDX_IRQ_HIGH, 8'hDF);
		pstrb <= 4'h0;
		apb(1'b1, IDX_IRQ_HIGH, 8'h00);
		pstrb <= 4'h1;
		rdc(IDX_IRQ_HIGH, 8'hDF);
		apb(1'b1, IDX_TIMER_CFG, 8'h0F);
		rdc(IDX_TIMER_CFG, 8'h07);
		repeat (70) @(posedge clk);
		expect_wakes(0, 1'b0);
		$display("registers done");
		apb(1'b1, IDX_INT_MASK, 8'h01);
		apb(1'b1, IDX_MODE, 8'h41);
		apb(1'b1, IDX_TIMER_CFG, 8'h08);
		expect_wakes(0, 1'b1);
		rdc(IDX_MODE, 8'h41);
		apb(1'b1, IDX_TIMER_CFG, 8'h00);
		src.irq_pulse(2);
		src.irq_pulse(13);
		src.vec_pulse();
		src.ext_pulse(1'b0, 40);
		expect_wakes(0, 1'b1);
		src.irq_pulse(3);
		expect_wakes(1, 1'b0);
		chk_irq(1'b1);
		apb(1'b1, IDX_INT_MASK, 8'h00);
		chk_irq(1'b0);
		apb(1'b1, IDX_INT_MASK, 8'h03);
		chk_irq(1'b1);
		rdc(IDX_INT_STAT, 8'h03);
		apb(1'b1, IDX_INT_STAT, 8'h03);
		chk_irq(1'b0);
		$display("force and irq done");
		apb(1'b1, IDX_TIMER_CFG, 8'h88);
		src.vec_pulse();
		expect_wakes(2, 1'b0);
		apb(1'b1, IDX_TIMER_CFG, 8'h08);
		src.irq_pulse(15);
		expect_wakes(3, 1'b0);
		apb(1'b1, IDX_MODE, 8'h01);
		apb(1'b1, IDX_TIMER_CFG, 8'h08);
		src.irq_pulse(3);
		expect_wakes(3, 1'b0);
		apb(1'b1, IDX_MODE, 8'h41);
		apb(1'b1, IDX_TIMER_CFG, 8'h48);
		src.ext_pulse(1'b0, 10);
		expect_wakes(3, 1'b1);
		src.ext_pulse(1'b0, 40);
		expect_wakes(4, 1'b0);
		src.ext_idle(1'b0);
		apb(1'b1, IDX_TIMER_CFG, 8'h78);
		src.ext_pulse(1'b1, 40);
		expect_wakes(4, 1'b1);
		src.ext_pulse(1'b1, 70);
		expect_wakes(5, 1'b0);
		foreach (lines[i]) begin
			apb(1'b1, IDX_TIMER_CFG, 8'h08);
			src.irq_pulse(lines[i]);
			expect_wakes(6 + i, 1'b0);
		end
		$display("wake sources done");
		apb(1'b1, IDX_MODE, 8'h45);
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, IDX_TIMER_CFG, {5'h00, k[2:0]});
			src.irq_pulse(3);
			n = 0;
			while (low !== 1'b1 && n < 2000) begin
				@(posedge clk);
				n++;
			end
			check(32'(n >= per[k] * 4 - 8 && n <= per[k] * 4 + 4), 32'h00000001);
			src.irq_pulse(3);
		end
		expect_wakes(19, 1'b0);
		rdc(IDX_MODE, 8'h4D);
		apb(1'b1, IDX_MODE, 8'h40);
		rdc(IDX_MODE, 8'h48);
		$display("periods done");
		final_report();
	end
endmodule : tb
